// [pkg/gpp_pkg.sv]
/*
  Package for the two-port pin function block: register offsets, field positions,
  reset values and the packed structs that carry pin and register traffic.
  Assumes a plain 8-bit register port with byte offsets of its own choosing.
*/
`default_nettype none
package gpp_pkg;
  localparam int GPP_AW = 4;
  localparam logic [3:0] GPP_OFS_FUNC_SEL = 4'h0;
  localparam logic [3:0] GPP_OFS_A_DIR = 4'h1;
  localparam logic [3:0] GPP_OFS_A_DATA = 4'h2;
  localparam logic [3:0] GPP_OFS_B_DIR = 4'h4;
  localparam logic [3:0] GPP_OFS_B_DATA = 4'h5;
  localparam logic [3:0] GPP_OFS_B_OTYPE = 4'h6;
  localparam logic [3:0] GPP_OFS_B_SEL = 4'h7;
  // Function select fields for the lower port-a pins
  localparam int GPP_FS_TIMER_OUT = 0;
  localparam int GPP_FS_PWM = 2;
  localparam int GPP_FS_INT0 = 4;
  localparam int GPP_FS_INT1 = 5;
  localparam logic [7:0] GPP_FS_MASK = 8'h35;
  localparam logic [7:0] GPP_A_PIN_MASK = 8'h37;
  localparam logic [7:0] GPP_A_DATA_RSV1 = 8'h08;
  localparam logic [4:0] GPP_B_PIN_MASK = 5'h1F;
  localparam logic [7:0] GPP_B_DATA_RSV1 = 8'hE0;
  localparam logic [7:0] GPP_B_OTYPE_RSV1 = 8'h07;
  localparam int GPP_OD_LO = 3;
  localparam logic [7:0] GPP_RST_ZERO = 8'h00;
  localparam logic [4:0] GPP_RST5 = 5'h00;

  typedef struct packed {
    logic [GPP_AW-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpp_bus_s;

  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
  } gpp_pins5_s;
endpackage : gpp_pkg
`default_nettype wire

// [hw/gpp_sync.sv]
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes an active-low asynchronous reset already released on the same clock.
*/
`default_nettype none
module gpp_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : gpp_sync
`default_nettype wire

// [hw/gpp_port12.sv]
/*
  Pin function logic for port a (lower pins with alternate functions) and the
  port b register set with pin drive. Registers sit on a plain 8-bit port with
  read data one cycle after the read strobe. Pins are split into in/out/enable.
  Peripherals supply their output levels and the port-b pin function overrides.
*/
// How it works
// - Pin a5 is input, output by direction, or interrupt-1/timer input if selected.
// - Pins a4, a1, a0 likewise give int-0, PWM, timer out; a2 is plain I/O.
// - Port-b peripheral selects override direction and data for each port-b pin.
// - Port-b direction bits 4..0 write-only, reset 0, 1 means output.
// - Port-b data holds output bits 4..0, reset 0; output pins read stored data.
// - Port-b data bits of input pins read the synchronised pin level.
// - Port-b data bits 7..5 always read 1.
// - Output-type bits 4 and 3 reset 0; 1 makes that pin open drain.
// - Output-type bits 7..5 read 0 and bits 2..0 read 1.
// - Function select bits are read/write and reset 0, so pins start as I/O.
`default_nettype none
module gpp_port12
  import gpp_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [GPP_AW-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [7:0] PA_IN,
  output logic [7:0] PA_OUT,
  output logic [7:0] PA_OE,
  output logic EXT_INTERRUPT_0,
  output logic EXT_INTERRUPT_1,
  output logic TIMER_B_EVENT_INPUT,
  input wire logic PWM_OUT_IN,
  input wire logic TIMER_W_OUTPUT_IN,
  input wire logic [4:0] PB_IN,
  output logic [4:0] PB_OUT,
  output logic [4:0] PB_OE,
  input wire logic [4:0] PB_PERIPH_SEL,
  input wire logic [4:0] PB_PERIPH_OUT,
  input wire logic [4:0] PB_PERIPH_OE,
  output logic [4:0] PB_PERIPH_IN
);
  logic rst_meta_q;
  logic rst_n_q;
  gpp_bus_s bus;
  logic [7:0] pa_sync;
  logic [4:0] pb_sync;
  logic [7:0] func_sel_q;
  logic [7:0] a_dir_q;
  logic [7:0] a_data_q;
  logic [4:0] b_dir_q;
  logic [4:0] b_data_q;
  logic [1:0] b_od_q;
  logic [7:0] rdata_d;
  logic [7:0] a_read;
  logic [4:0] b_read;
  logic [4:0] b_od;
  gpp_pins5_s pb_d;
  logic [7:0] pa_out_d;
  logic [7:0] pa_oe_d;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // Pins are asynchronous to MCLK, so every read sees them two flops late
  gpp_sync #(.W(13)) u_sync (
    .clk(MCLK),
    .rst_n(rst_n_q),
    .d({PB_IN, PA_IN}),
    .q({pb_sync, pa_sync})
  );

  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      func_sel_q <= GPP_RST_ZERO;
    end else if (bus.wr && bus.addr == GPP_OFS_FUNC_SEL) begin
      func_sel_q <= bus.wdata & GPP_FS_MASK;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      a_dir_q <= GPP_RST_ZERO;
      a_data_q <= GPP_RST_ZERO;
    end else if (bus.wr) begin
      if (bus.addr == GPP_OFS_A_DIR) begin
        a_dir_q <= bus.wdata & GPP_A_PIN_MASK;
      end
      if (bus.addr == GPP_OFS_A_DATA) begin
        a_data_q <= bus.wdata & GPP_A_PIN_MASK;
      end
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      b_dir_q <= GPP_RST5;
      b_data_q <= GPP_RST5;
      b_od_q <= 2'b00;
    end else if (bus.wr) begin
      // Only the defined bit slices are stored, reserved bits never reach a flop
      if (bus.addr == GPP_OFS_B_DIR) begin
        b_dir_q <= bus.wdata[4:0];
      end
      if (bus.addr == GPP_OFS_B_DATA) begin
        b_data_q <= bus.wdata[4:0];
      end
      if (bus.addr == GPP_OFS_B_OTYPE) begin
        b_od_q <= bus.wdata[4:GPP_OD_LO];
      end
    end
  end

  // Read mux: input pins show level, output pins show stored data
  always_comb begin
    a_read = (a_dir_q & a_data_q) | (~a_dir_q & pa_sync & GPP_A_PIN_MASK);
    a_read = a_read | GPP_A_DATA_RSV1;
    b_read = (b_dir_q & b_data_q) | (~b_dir_q & pb_sync);
    rdata_d = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        GPP_OFS_FUNC_SEL: rdata_d = func_sel_q;
        GPP_OFS_A_DATA: rdata_d = a_read;
        GPP_OFS_B_DATA: rdata_d = GPP_B_DATA_RSV1 | {3'b000, b_read};
        GPP_OFS_B_OTYPE: rdata_d = {3'b000, b_od_q, 3'b000} | GPP_B_OTYPE_RSV1;
        GPP_OFS_B_SEL: rdata_d = {3'b000, PB_PERIPH_SEL};
        // Direction registers are write-only and read as zero
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Alternate function overrides direction for each selectable pin
  always_comb begin
    pa_out_d = a_data_q;
    pa_oe_d = a_dir_q & GPP_A_PIN_MASK;
    if (func_sel_q[GPP_FS_INT1]) begin
      pa_oe_d[5] = 1'b0;
    end
    if (func_sel_q[GPP_FS_INT0]) begin
      pa_oe_d[4] = 1'b0;
    end
    if (func_sel_q[GPP_FS_PWM]) begin
      pa_out_d[1] = PWM_OUT_IN;
      pa_oe_d[1] = 1'b1;
    end
    if (func_sel_q[GPP_FS_TIMER_OUT]) begin
      pa_out_d[0] = TIMER_W_OUTPUT_IN;
      pa_oe_d[0] = 1'b1;
    end
  end

  assign b_od = {b_od_q, 3'b000};

  // Peripheral owns the pin when selected; open drain drives only the low level
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pb_d.out[i] = PB_PERIPH_SEL[i] ? PB_PERIPH_OUT[i] : b_data_q[i];
      pb_d.oe[i] = PB_PERIPH_SEL[i] ? PB_PERIPH_OE[i] : b_dir_q[i];
      if (b_od[i] && pb_d.out[i]) begin
        pb_d.oe[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= rdata_d;
    end
  end

  // Outputs are registered, costing one cycle of pin latency
  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PA_OUT <= 8'h00;
      PA_OE <= 8'h00;
      PB_OUT <= 5'h00;
      PB_OE <= 5'h00;
      PB_PERIPH_IN <= 5'h00;
      EXT_INTERRUPT_0 <= 1'b0;
      EXT_INTERRUPT_1 <= 1'b0;
      TIMER_B_EVENT_INPUT <= 1'b0;
    end else begin
      PA_OUT <= pa_out_d;
      PA_OE <= pa_oe_d;
      PB_OUT <= pb_d.out;
      PB_OE <= pb_d.oe;
      PB_PERIPH_IN <= pb_sync & PB_PERIPH_SEL;
      EXT_INTERRUPT_0 <= func_sel_q[GPP_FS_INT0] & pa_sync[4];
      EXT_INTERRUPT_1 <= func_sel_q[GPP_FS_INT1] & pa_sync[5];
      TIMER_B_EVENT_INPUT <= func_sel_q[GPP_FS_INT1] & pa_sync[5];
    end
  end
endmodule : gpp_port12
`default_nettype wire

// [tb/gpp_port12_chk.sv]
/* Checker for gpp_port12: pin muxing and port-b register reads.
   Assumes it is bound into the top module and sees only its ports. */
`default_nettype none
module gpp_port12_chk
  import gpp_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [GPP_AW-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] PA_OUT,
  input wire logic [7:0] PA_OE,
  input wire logic EXT_INTERRUPT_1,
  input wire logic PWM_OUT_IN,
  input wire logic TIMER_W_OUTPUT_IN,
  input wire logic [4:0] PB_OUT,
  input wire logic [4:0] PB_OE,
  input wire logic [4:0] PB_PERIPH_SEL,
  input wire logic [4:0] PB_PERIPH_OUT,
  input wire logic [4:0] PB_PERIPH_OE
);
  logic [7:0] fs_q;
  logic [4:3] od_q;
  // Shadow copies, since the registers are not visible at the ports
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fs_q <= 8'h00;
      od_q <= 2'h0;
    end else if (WR && ADDR == GPP_OFS_FUNC_SEL) begin
      fs_q <= WDATA;
    end else if (WR && ADDR == GPP_OFS_B_OTYPE) begin
      od_q <= WDATA[4:3];
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  chk_bdat_rsv: assert property (
    RD && ADDR == GPP_OFS_B_DATA |=> RDATA[7:5] == 3'h7) else $error("data reserved bits");
  chk_otype_rsv: assert property (
    RD && ADDR == GPP_OFS_B_OTYPE |=> RDATA[7:5] == 3'h0 && RDATA[2:0] == 3'h7)
    else $error("output type reserved bits");
  chk_int1_gate: assert property (
    !fs_q[5] |=> !EXT_INTERRUPT_1) else $error("interrupt 1 without select");
  chk_a5_input: assert property (
    fs_q[5] |=> !PA_OE[5]) else $error("pin a5 driven while selected");
  chk_pwm_out: assert property (
    fs_q[2] |=> PA_OE[1] && PA_OUT[1] == $past(PWM_OUT_IN)) else $error("pwm pin");
  chk_tmr_out: assert property (
    fs_q[0] |=> PA_OE[0] && PA_OUT[0] == $past(TIMER_W_OUTPUT_IN)) else $error("timer pin");
  chk_open_drain: assert property (
    od_q[4] && !PB_PERIPH_SEL[4] |=> !(PB_OE[4] && PB_OUT[4])) else $error("pin b4 high");
  chk_periph_own: assert property (
    PB_PERIPH_SEL[0] |=> PB_OE[0] == $past(PB_PERIPH_OE[0])
    && PB_OUT[0] == $past(PB_PERIPH_OUT[0])) else $error("peripheral drive");
endmodule : gpp_port12_chk
bind gpp_port12 gpp_port12_chk i_chk (.*);
`default_nettype wire

// [tb/gpp_pins_model.sv]
/* Pin model: an undriven pin takes the outside level.
   Assumes the outside level stands for a pull or an external driver. */
`default_nettype none
module gpp_pins_model (
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_ext,
  output logic [7:0] pa_in,
  input wire logic [4:0] pb_out,
  input wire logic [4:0] pb_oe,
  input wire logic [4:0] pb_ext,
  output logic [4:0] pb_in
);
  timeunit 1ns;
  timeprecision 100ps;
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);
endmodule : gpp_pins_model
`default_nettype wire

// [tb/tb.sv]
/* Testbench for gpp_port12: register table, then pin cases.
   Assumes the checker is bound by its own file. */
`default_nettype none
module tb;
  import gpp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic MCLK, RESET_N, WR, RD, PWM_OUT_IN, TIMER_W_OUTPUT_IN;
  logic EXT_INTERRUPT_0, EXT_INTERRUPT_1, TIMER_B_EVENT_INPUT;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RDATA, PA_IN, PA_OUT, PA_OE, pa_ext;
  logic [4:0] PB_IN, PB_OUT, PB_OE, PB_PERIPH_SEL, PB_PERIPH_OUT, PB_PERIPH_OE;
  logic [4:0] PB_PERIPH_IN, pb_ext;
  int err_total, check_count;
  localparam logic [19:0] ROWS [8] = '{{GPP_OFS_B_DIR, 8'hFF, 8'h00},
    {GPP_OFS_B_DATA, 8'hFF, 8'hFF}, {GPP_OFS_B_DATA, 8'h0A, 8'hEA},
    {GPP_OFS_B_OTYPE, 8'hFF, 8'h1F}, {GPP_OFS_B_OTYPE, 8'h00, 8'h07},
    {GPP_OFS_FUNC_SEL, 8'hFF, 8'h35}, {GPP_OFS_FUNC_SEL, 8'h00, 8'h00},
    {4'h3, 8'hFF, 8'h00}};
  gpp_port12 i_dut (.*);
  gpp_pins_model i_pins (.pa_out(PA_OUT), .pa_oe(PA_OE), .pa_ext(pa_ext), .pa_in(PA_IN),
    .pb_out(PB_OUT), .pb_oe(PB_OE), .pb_ext(pb_ext), .pb_in(PB_IN));
  always #2 MCLK = ~MCLK;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 chk(RDATA, e);
    // Read data stand for one cycle only, then the port returns to zero
    @(posedge MCLK);
    #1 chk(RDATA, 8'h00);
  endtask : rdc
  // Four edges cover the register, the pin stage and the input synchroniser
  task automatic settle;
    repeat (4) @(posedge MCLK);
    #1;
  endtask : settle
  task automatic print_verdict;
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2000) @(posedge MCLK);
    err_total++;
    print_verdict();
  end
  initial begin
    {MCLK, RESET_N, WR, RD, PWM_OUT_IN, TIMER_W_OUTPUT_IN, ADDR, WDATA} = '0;
    {PB_PERIPH_SEL, PB_PERIPH_OUT, PB_PERIPH_OE} = '0;
    pa_ext = 8'h20;
    pb_ext = 5'h0A;
    repeat (5) @(posedge MCLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    chk({3'h0, PB_OE}, 8'h00);
    rdc(GPP_OFS_B_OTYPE, 8'h07);
    rdc(GPP_OFS_FUNC_SEL, 8'h00);
    rdc(GPP_OFS_B_DATA, 8'hEA);
    foreach (ROWS[i]) begin
      wr(ROWS[i][19:16], ROWS[i][15:8]);
      rdc(ROWS[i][19:16], ROWS[i][7:0]);
    end
    settle();
    chk({3'h0, PB_OE}, 8'h1F);
    chk({3'h0, PB_OUT}, 8'h0A);
    wr(GPP_OFS_B_DIR, 8'h03);
    wr(GPP_OFS_B_DATA, 8'h15);
    rdc(GPP_OFS_B_DATA, 8'hE9);
    wr(GPP_OFS_B_DIR, 8'h1F);
    wr(GPP_OFS_B_DATA, 8'h18);
    wr(GPP_OFS_B_OTYPE, 8'h18);
    PB_PERIPH_SEL <= 5'h03;
    PB_PERIPH_OUT <= 5'h03;
    PB_PERIPH_OE <= 5'h01;
    settle();
    chk({3'h0, PB_OE}, 8'h05);
    chk({7'h0, PB_OUT[0]}, 8'h01);
    chk({3'h0, PB_PERIPH_IN}, 8'h03);
    rdc(GPP_OFS_B_SEL, 8'h03);
    wr(GPP_OFS_A_DIR, 8'hFF);
    settle();
    chk(PA_OE, GPP_A_PIN_MASK);
    PWM_OUT_IN <= 1'b1;
    wr(GPP_OFS_FUNC_SEL, 8'h35);
    settle();
    chk(PA_OE, 8'h07);
    chk({6'h0, PA_OUT[1:0]}, 8'h02);
    chk({5'h0, EXT_INTERRUPT_1, TIMER_B_EVENT_INPUT, EXT_INTERRUPT_0}, 8'h06);
    wr(GPP_OFS_FUNC_SEL, 8'h00);
    wr(GPP_OFS_A_DIR, 8'h00);
    settle();
    chk({PA_OE[7:1], EXT_INTERRUPT_1}, 8'h00);
    rdc(GPP_OFS_A_DATA, 8'h28);
    // Mid-run reset: peripheral ownership is dropped first; no port-b drive is expected while reset is low
    PB_PERIPH_SEL <= 5'h00;
    wr(GPP_OFS_B_DATA, 8'h1F);
    RESET_N <= 1'b0;
    @(posedge MCLK);
    #1 chk({3'h0, PB_OE}, 8'h00);
    @(posedge MCLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    rdc(GPP_OFS_B_DATA, 8'hEA);
    rdc(GPP_OFS_B_OTYPE, 8'h07);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
